// File: hdl/slam_err_if.sv
// interface carrying one error window between the monitor and its error counter
// assumes both ends run on the same clock
`default_nettype none
interface slam_err_if;
  logic tick;
  logic err;
  logic clear;
  logic lost;
  modport mon (output tick, output err, output clear, input lost);
  modport win (input tick, input err, input clear, output lost);
endinterface : slam_err_if
`default_nettype wire

// File: hdl/slam_err_window.sv
// counts errors over a window of ticks and flags loss at a threshold
// assumes tick/err/clear are same-clock pulses
`default_nettype none
module slam_err_window #(
  parameter int unsigned WINDOW    = 64,
  parameter int unsigned THRESHOLD = 4
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  slam_err_if.win   e
);
  import slam_pkg::*;
  initial begin
    if (THRESHOLD < 2 || THRESHOLD > WINDOW || WINDOW > 255) begin
      $error("slam_err_window: bad window/threshold");
    end
  end
  logic [ERR_CNT_W-1:0] tick_reg, tick_next;
  logic [ERR_CNT_W-1:0] err_reg, err_next;
  logic                 lost_reg, lost_next;

  always_comb begin
    tick_next = tick_reg;
    err_next  = err_reg;
    lost_next = 1'b0;
    if (e.clear) begin
      tick_next = '0;
      err_next  = '0;
    end else if (e.tick) begin
      // a single error is tolerated; loss only at the threshold inside a window
      if (e.err && (err_reg + 1'b1) >= ERR_CNT_W'(THRESHOLD)) begin
        lost_next = 1'b1;
        tick_next = '0;
        err_next  = '0;
      end else if (tick_reg == ERR_CNT_W'(WINDOW - 1)) begin
        tick_next = '0;
        err_next  = '0;
      end else begin
        tick_next = tick_reg + 1'b1;
        err_next  = err_reg + {{(ERR_CNT_W-1){1'b0}}, e.err};
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      tick_reg <= '0;
      err_reg  <= '0;
      lost_reg <= 1'b0;
    end else begin
      tick_reg <= tick_next;
      err_reg  <= err_next;
      lost_reg <= lost_next;
    end
  end
  assign e.lost = lost_reg;
endmodule : slam_err_window
`default_nettype wire

// File: hdl/slam_monitor.sv
// receiver-side alignment monitor and link bring-up control for a 64b/66b link
// assumes header/header_valid come from a deserializer in another domain (synchronised here)
// Functional notes
// - header must be 01 or 10
// - block lock lost after several header errors
// - pilot 00001 ends each multiblock header stream
// - repeated bad pilots drop multiblock lock
// - wrong extended flag repeatedly forces realignment
// - three lock levels tracked, each dropped when a level below it loses lock
// - request sysref after multiblock lock loss (not requested here when a block lock loss drops multiblock lock)
// - clear enable before changing link parameters
// - set enable once parameters are programmed
// - release point offset by rbd frame clocks
// - rbd zero releases on the edge (release_out here comes one cycle after lemc_edge_out)
// - bad release point varies latency
// - data arrives between release points
// - multiblock is 32 blocks, 2048 bits
`default_nettype none
module slam_monitor #(
  parameter int unsigned BLK_WINDOW = 64,
  parameter int unsigned BLK_THRESH = 16,
  parameter int unsigned MB_WINDOW  = 8,
  parameter int unsigned MB_THRESH  = 4,
  parameter int unsigned EMB_WINDOW = 8,
  parameter int unsigned EMB_THRESH = 4,
  parameter int unsigned PE_W       = 4
) (
  input  wire logic            clk_in,
  input  wire logic            rst_b_in,
  input  wire logic [1:0]      header_in,
  input  wire logic            header_valid_in,
  input  wire logic            sysref_done_in,
  input  wire logic            cfg_req_in,
  input  wire logic [7:0]      cfg_emb_len_in,
  input  wire logic [7:0]      cfg_rbd_in,
  input  wire logic [PE_W-1:0] cfg_preemph_in,
  output logic                 link_enable_out,
  output logic [PE_W-1:0]      serializer_preemphasis_level_out,
  output logic                 sysref_req_out,
  output logic                 block_lock_out,
  output logic                 mb_lock_out,
  output logic                 emb_lock_out,
  output logic                 lemc_edge_out,
  output logic                 release_out,
  output logic                 realign_out
);
  import slam_pkg::*;
  initial begin
    if (BLK_THRESH < 2 || MB_THRESH < 2 || EMB_THRESH < 2 || PE_W < 1 || PE_W > 8) begin
      $error("slam_monitor: unsupported parameters");
    end
  end

  // two-flop synchronisers for the header_in and header_valid_in pin inputs
  logic [2:0] s1_reg, s2_reg;
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= {header_valid_in, header_in};
      s2_reg <= s1_reg;
    end
  end
  logic [1:0] hdr;
  logic       hv;
  assign hdr = s2_reg[1:0];
  assign hv  = s2_reg[2];

  // enable and configuration sequencing
  logic            en_reg, en_next;
  logic [PE_W-1:0] pe_reg, pe_next;
  logic [7:0]      emb_len_reg, emb_len_next;
  logic [7:0]      rbd_reg, rbd_next;
  logic            cfg_pend_reg, cfg_pend_next;
  always_comb begin
    en_next       = en_reg;
    pe_next       = pe_reg;
    emb_len_next  = emb_len_reg;
    rbd_next      = rbd_reg;
    cfg_pend_next = cfg_pend_reg;
    if (cfg_req_in) begin
      en_next       = 1'b0;
      cfg_pend_next = 1'b1;
    end else if (cfg_pend_reg) begin
      // parameters only change while the link is already held disabled
      pe_next       = cfg_preemph_in;
      emb_len_next  = (cfg_emb_len_in == 8'h00) ? RST_EMB_LEN : cfg_emb_len_in;
      rbd_next      = cfg_rbd_in;
      cfg_pend_next = 1'b0;
      en_next       = 1'b1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      en_reg       <= 1'b0;
      pe_reg       <= '0;
      emb_len_reg  <= RST_EMB_LEN;
      rbd_reg      <= RST_RBD;
      cfg_pend_reg <= 1'b1;
    end else begin
      en_reg       <= en_next;
      pe_reg       <= pe_next;
      emb_len_reg  <= emb_len_next;
      rbd_reg      <= rbd_next;
      cfg_pend_reg <= cfg_pend_next;
    end
  end

  // lock tracking
  logic       hdr_ok;
  assign hdr_ok = hdr[1] ^ hdr[0];
  slam_lock_e            blk_st_reg, blk_st_next;
  slam_lock_e            mb_st_reg, mb_st_next;
  slam_lock_e            emb_st_reg, emb_st_next;
  logic [MB_CNT_W-1:0]   bpos_reg, bpos_next;
  logic [4:0]            tail_reg, tail_next;
  logic                  flag_reg, flag_next;
  logic [EMB_CNT_W-1:0]  mbpos_reg, mbpos_next;
  logic                  sreq_reg, sreq_next;
  logic                  lemc_reg, lemc_next;
  logic [7:0]            rcnt_reg, rcnt_next;
  logic                  rel_arm_reg, rel_arm_next;
  logic                  rel_reg, rel_next;
  logic                  realign_reg, realign_next;

  slam_err_if blk_e ();
  slam_err_if mb_e ();
  slam_err_if emb_e ();
  slam_err_window #(.WINDOW(BLK_WINDOW), .THRESHOLD(BLK_THRESH)) u_blk (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .e        (blk_e)
  );
  slam_err_window #(.WINDOW(MB_WINDOW), .THRESHOLD(MB_THRESH)) u_mb (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .e        (mb_e)
  );
  slam_err_window #(.WINDOW(EMB_WINDOW), .THRESHOLD(EMB_THRESH)) u_emb (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .e        (emb_e)
  );

  logic blk_step, mb_end, pilot_ok, emb_last, flag_ok;
  assign blk_step = hv && en_reg && (blk_st_reg == SLAM_LOCKED);
  assign mb_end   = blk_step && (bpos_reg == MB_CNT_W'(BLOCKS_PER_MB - 1));
  // header stream bit = second header bit; last five bits form the pilot
  assign pilot_ok = ({tail_reg[3:0], hdr[0]} == PILOT_PATTERN);
  assign emb_last = (mbpos_reg == emb_len_reg - 8'h01);
  assign flag_ok  = (flag_reg == emb_last);

  assign blk_e.tick  = hv && en_reg && (blk_st_reg != SLAM_HUNT);
  assign blk_e.err   = !hdr_ok;
  assign blk_e.clear = !en_reg || (blk_st_reg == SLAM_HUNT);
  assign mb_e.tick   = mb_end && (mb_st_reg != SLAM_HUNT);
  assign mb_e.err    = !pilot_ok;
  assign mb_e.clear  = (mb_st_reg == SLAM_HUNT);
  assign emb_e.tick  = mb_end && (emb_st_reg == SLAM_LOCKED);
  assign emb_e.err   = !flag_ok;
  assign emb_e.clear = (emb_st_reg != SLAM_LOCKED);

  always_comb begin
    blk_st_next  = blk_st_reg;
    mb_st_next   = mb_st_reg;
    emb_st_next  = emb_st_reg;
    bpos_next    = bpos_reg;
    tail_next    = tail_reg;
    flag_next    = flag_reg;
    mbpos_next   = mbpos_reg;
    sreq_next    = sreq_reg;
    realign_next = 1'b0;
    // block level
    case (blk_st_reg)
      SLAM_HUNT: begin
        if (hv && en_reg && hdr_ok) blk_st_next = SLAM_VERIFY;
      end
      SLAM_VERIFY: begin
        if (hv) blk_st_next = hdr_ok ? SLAM_LOCKED : SLAM_HUNT;
      end
      SLAM_LOCKED: begin
        if (blk_e.lost) blk_st_next = SLAM_HUNT;
      end
      default: blk_st_next = SLAM_HUNT;
    endcase
    // a disabled link sends nothing meaningful, so block lock cannot survive it
    if (!en_reg) blk_st_next = SLAM_HUNT;
    if (blk_step) begin
      bpos_next = bpos_reg + 1'b1;
      tail_next = {tail_reg[3:0], hdr[0]};
      if (bpos_reg == MB_CNT_W'(EMB_FLAG_POS)) flag_next = hdr[0];
    end
    // multiblock level, independent of the others once blocks lock
    case (mb_st_reg)
      SLAM_HUNT: if (blk_step && pilot_ok) begin
        mb_st_next = SLAM_LOCKED;
        bpos_next  = '0;
      end
      SLAM_LOCKED: if (mb_e.lost) begin
        mb_st_next   = SLAM_HUNT;
        sreq_next    = 1'b1;
        realign_next = 1'b1;
      end
      default: mb_st_next = SLAM_HUNT;
    endcase
    // extended multiblock level
    if (mb_end) mbpos_next = emb_last ? '0 : mbpos_reg + 1'b1;
    case (emb_st_reg)
      SLAM_HUNT: if (mb_end && mb_st_reg == SLAM_LOCKED && flag_reg) begin
        emb_st_next = SLAM_LOCKED;
        mbpos_next  = '0;
      end
      SLAM_LOCKED: if (emb_e.lost || mb_st_next == SLAM_HUNT) begin
        emb_st_next  = SLAM_HUNT;
        sreq_next    = 1'b1;
        realign_next = 1'b1;
      end
      default: emb_st_next = SLAM_HUNT;
    endcase
    // a loss in the sysref_done cycle wins, so the fresh request stands
    if (sysref_done_in && !realign_next) begin
      sreq_next = 1'b0;
    end
    // loss of block lock drops everything above it
    if (blk_st_next != SLAM_LOCKED) begin
      mb_st_next  = SLAM_HUNT;
      emb_st_next = SLAM_HUNT;
    end
  end

  // release point: rbd+1 cycles after lemc_edge_out
  always_comb begin
    lemc_next    = mb_end && emb_last && (emb_st_reg == SLAM_LOCKED);
    rcnt_next    = rcnt_reg;
    rel_arm_next = rel_arm_reg;
    rel_next     = 1'b0;
    if (lemc_reg) begin
      if (rbd_reg == 8'h00) begin
        rel_next = 1'b1;
      end else begin
        rel_arm_next = 1'b1;
        rcnt_next    = rbd_reg;
      end
    end else if (rel_arm_reg) begin
      // limitation: counts frame clocks as core cycles; rbd must stay below the lemc period
      rcnt_next = rcnt_reg - 8'h01;
      if (rcnt_reg == 8'h01) begin
        rel_next     = 1'b1;
        rel_arm_next = 1'b0;
      end
    end
    if (emb_st_reg != SLAM_LOCKED) rel_arm_next = 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      blk_st_reg  <= SLAM_HUNT;
      mb_st_reg   <= SLAM_HUNT;
      emb_st_reg  <= SLAM_HUNT;
      bpos_reg    <= '0;
      tail_reg    <= '0;
      flag_reg    <= 1'b0;
      mbpos_reg   <= '0;
      sreq_reg    <= 1'b0;
      lemc_reg    <= 1'b0;
      rcnt_reg    <= '0;
      rel_arm_reg <= 1'b0;
      rel_reg     <= 1'b0;
      realign_reg <= 1'b0;
    end else begin
      blk_st_reg  <= blk_st_next;
      mb_st_reg   <= mb_st_next;
      emb_st_reg  <= emb_st_next;
      bpos_reg    <= bpos_next;
      tail_reg    <= tail_next;
      flag_reg    <= flag_next;
      mbpos_reg   <= mbpos_next;
      sreq_reg    <= sreq_next;
      lemc_reg    <= lemc_next;
      rcnt_reg    <= rcnt_next;
      rel_arm_reg <= rel_arm_next;
      rel_reg     <= rel_next;
      realign_reg <= realign_next;
    end
  end

  assign link_enable_out                  = en_reg;
  assign serializer_preemphasis_level_out = pe_reg;
  assign sysref_req_out                   = sreq_reg;
  assign block_lock_out                   = (blk_st_reg == SLAM_LOCKED);
  assign mb_lock_out                      = (mb_st_reg == SLAM_LOCKED);
  assign emb_lock_out                     = (emb_st_reg == SLAM_LOCKED);
  assign lemc_edge_out                    = lemc_reg;
  assign release_out                      = rel_reg;
  assign realign_out                      = realign_reg;
endmodule : slam_monitor
`default_nettype wire

// File: hdl/slam_pkg.sv
// package for the serial link alignment monitor (receiver side of a 64b/66b link)
// assumes a single 25 MHz clock; sync headers arrive one per block from a deserializer
package slam_pkg;
  localparam int unsigned BLOCKS_PER_MB      = 32;
  localparam int unsigned MB_PAYLOAD_BITS    = 2048;
  localparam int unsigned PILOT_WIDTH        = 5;
  localparam logic [4:0]  PILOT_PATTERN      = 5'h01;
  localparam int unsigned EMB_FLAG_POS       = 22;
  localparam int unsigned MB_CNT_W           = 5;
  localparam int unsigned EMB_CNT_W          = 8;
  localparam int unsigned ERR_CNT_W          = 8;
  localparam logic [7:0]  RST_EMB_LEN        = 8'h01;
  localparam logic [7:0]  RST_RBD            = 8'h00;

  typedef enum logic [1:0] {
    SLAM_HUNT   = 2'b00,
    SLAM_VERIFY = 2'b01,
    SLAM_LOCKED = 2'b11
  } slam_lock_e;
endpackage : slam_pkg

// File: tb/slam_dev_model.sv
// device model: transmits the sync header stream, one block every two cycles
// assumes bench clock; fault inputs come from the bench
`default_nettype none
module slam_dev_model #(
  parameter int unsigned PE_W = 4
) (
  input  wire logic            clk_in,
  input  wire logic            rst_b_in,
  input  wire logic            link_enable_in,
  input  wire logic [7:0]      emb_len_in,
  input  wire logic [PE_W-1:0] preemph_in,
  input  wire logic            sysref_req_in,
  input  wire logic            bad_hdr_in,
  input  wire logic            bad_pilot_in,
  input  wire logic            bad_flag_in,
  output logic [1:0]           header_out,
  output logic                 header_valid_out,
  output logic                 sysref_done_out
);
  logic [4:0]      blk_reg;
  logic [7:0]      mb_reg;
  logic [2:0]      sr_reg;
  logic [PE_W-1:0] pe_reg;
  logic            ph_reg;
  logic            bit_v;
  logic            last_mb;
  // zero length acts as one multiblock
  assign last_mb = (mb_reg + 8'h01 >= emb_len_in);
  always_comb begin
    bit_v = 1'b1;
    if (blk_reg >= 5'h1b && blk_reg <= 5'h1e) bit_v = 1'b0;
    if (blk_reg == 5'h1f) bit_v = !bad_pilot_in;
    if (blk_reg == 5'h16) bit_v = last_mb ^ bad_flag_in;
  end
  initial begin
    header_out = 2'h0;
    header_valid_out = 1'b0;
    sysref_done_out = 1'b0;
    ph_reg = 1'b0;
  end
  always @(negedge clk_in) begin
    header_valid_out <= 1'b0;
    sysref_done_out <= 1'b0;
    ph_reg <= !ph_reg;
    // idle pins keep toggling so a stale value never looks valid
    header_out <= {ph_reg, !ph_reg};
    if (!rst_b_in || !link_enable_in) begin
      blk_reg <= 5'h00;
      mb_reg <= 8'h00;
      sr_reg <= 3'h0;
      pe_reg <= preemph_in;
    end else if (sysref_req_in && sr_reg == 3'h4) begin
      blk_reg <= 5'h00;
      mb_reg <= 8'h00;
      sr_reg <= 3'h0;
      sysref_done_out <= 1'b1;
    end else begin
      sr_reg <= sysref_req_in ? sr_reg + 3'h1 : 3'h0;
      if (ph_reg) begin
        header_out <= bad_hdr_in ? 2'h0 : {!bit_v, bit_v};
        header_valid_out <= 1'b1;
        blk_reg <= blk_reg + 5'h01;
        if (blk_reg == 5'h1f) mb_reg <= last_mb ? 8'h00 : mb_reg + 8'h01;
      end
    end
  end
endmodule : slam_dev_model
`default_nettype wire

// File: tb/slam_monitor_checker.sv
// checker: port timing of the alignment monitor
// assumes bind to slam_monitor, one clock, sync active-low reset
`default_nettype none
module slam_monitor_checker #(
  parameter int unsigned PE_W = 4
) (
  input wire logic            clk_in,
  input wire logic            rst_b_in,
  input wire logic            cfg_req_in,
  input wire logic [7:0]      cfg_rbd_in,
  input wire logic [PE_W-1:0] cfg_preemph_in,
  input wire logic            sysref_done_in,
  input wire logic            link_enable_out,
  input wire logic [PE_W-1:0] serializer_preemphasis_level_out,
  input wire logic            sysref_req_out,
  input wire logic            block_lock_out,
  input wire logic            mb_lock_out,
  input wire logic            emb_lock_out,
  input wire logic            lemc_edge_out,
  input wire logic            release_out,
  input wire logic            realign_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  enable_drop_a: assert property (cfg_req_in |=> !link_enable_out)
    else $error("enable high under config request");
  enable_rise_a: assert property (!cfg_req_in && $past(cfg_req_in) |=> link_enable_out)
    else $error("enable not restored");
  disabled_idle_a: assert property (!link_enable_out [*2] |->
    !block_lock_out && !mb_lock_out && !emb_lock_out) else $error("lock while disabled");
  lock_order_a: assert property (!block_lock_out |-> !mb_lock_out && !emb_lock_out)
    else $error("upper lock kept without block lock");
  realign_req_a: assert property (realign_out |-> sysref_req_out && !emb_lock_out)
    else $error("realign without sysref request");
  sysref_hold_a: assert property (sysref_req_out && !sysref_done_in |=> sysref_req_out)
    else $error("sysref request dropped early");
  release_zero_a: assert property (lemc_edge_out && cfg_rbd_in == 8'h00 |=> release_out)
    else $error("release not after edge");
  lemc_gap_a: assert property (lemc_edge_out |=> !lemc_edge_out [*8])
    else $error("edge too soon");
  preemph_load_a: assert property ($rose(link_enable_out) |->
    serializer_preemphasis_level_out == $past(cfg_preemph_in)) else $error("preemph not loaded");
endmodule : slam_monitor_checker
bind slam_monitor slam_monitor_checker #(.PE_W(PE_W)) u_chk (.clk_in(clk_in),
  .rst_b_in(rst_b_in), .cfg_req_in(cfg_req_in), .cfg_rbd_in(cfg_rbd_in),
  .cfg_preemph_in(cfg_preemph_in), .sysref_done_in(sysref_done_in),
  .link_enable_out(link_enable_out),
  .serializer_preemphasis_level_out(serializer_preemphasis_level_out),
  .sysref_req_out(sysref_req_out), .block_lock_out(block_lock_out),
  .mb_lock_out(mb_lock_out), .emb_lock_out(emb_lock_out), .lemc_edge_out(lemc_edge_out),
  .release_out(release_out), .realign_out(realign_out));
`default_nettype wire

// File: tb/slam_monitor_tb.sv
// testbench: alignment monitor against the device model
// assumes checker bound from its own file; inputs change at falling edges
`default_nettype none
module slam_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BLK = 0, MB = 1, EMB = 2, LEMC = 3, REL = 4, RLN = 5;
  logic       clk_in, rst_b_in, header_valid, sysref_done, cfg_req;
  logic [1:0] header;
  logic [7:0] emb_len, rbd;
  logic [3:0] pe, pe_out;
  logic       bad_hdr, bad_pilot, bad_flag, enable, sysref_req;
  logic       blk_lock, mb_lock, emb_lock, lemc, rel, realign;
  int         error_cnt = 0;
  int         checks = 0;
  int         n;
  slam_monitor #(.BLK_THRESH(3), .MB_WINDOW(128), .MB_THRESH(2),
    .EMB_WINDOW(128), .EMB_THRESH(2)) dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .header_in(header), .header_valid_in(header_valid), .sysref_done_in(sysref_done),
    .cfg_req_in(cfg_req), .cfg_emb_len_in(emb_len), .cfg_rbd_in(rbd), .cfg_preemph_in(pe),
    .link_enable_out(enable), .serializer_preemphasis_level_out(pe_out),
    .sysref_req_out(sysref_req), .block_lock_out(blk_lock), .mb_lock_out(mb_lock),
    .emb_lock_out(emb_lock), .lemc_edge_out(lemc), .release_out(rel), .realign_out(realign));
  slam_dev_model u_dev (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .link_enable_in(enable), .emb_len_in(emb_len), .preemph_in(pe_out),
    .sysref_req_in(sysref_req), .bad_hdr_in(bad_hdr), .bad_pilot_in(bad_pilot),
    .bad_flag_in(bad_flag), .header_out(header), .header_valid_out(header_valid),
    .sysref_done_out(sysref_done));
  task automatic stop_test();
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic sig(input int k);
    case (k)
      BLK: return blk_lock;
      MB: return mb_lock;
      EMB: return emb_lock;
      LEMC: return lemc;
      REL: return rel;
      default: return realign;
    endcase
  endfunction : sig
  // outputs are read at falling edges, half a cycle after they settle
  task automatic wait_for(input int k, input logic v);
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (sig(k) !== v && n < 20000);
    chk(sig(k), v);
  endtask : wait_for
  task automatic edge_chk(input logic [31:0] per, input logic [31:0] dly);
    wait_for(LEMC, 1'b1);
    wait_for(LEMC, 1'b1);
    chk(n, per);
    wait_for(REL, 1'b1);
    chk(n, dly);
  endtask : edge_chk
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = !clk_in;
  end
  initial begin
    repeat (60000) @(posedge clk_in);
    error_cnt++;
    stop_test();
  end
  initial begin
    rst_b_in = 1'b0;
    cfg_req = 1'b0;
    emb_len = 8'h02;
    rbd = 8'h00;
    pe = 4'h5;
    bad_hdr = 1'b0;
    bad_pilot = 1'b0;
    bad_flag = 1'b0;
    repeat (20) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (2) @(negedge clk_in);
    chk(enable, 1'b1);
    chk(pe_out, 32'h5);
    wait_for(EMB, 1'b1);
    chk(mb_lock, 1'b1);
    edge_chk(32'h80, 32'h1);
    bad_hdr = 1'b1;
    repeat (2) @(negedge clk_in);
    bad_hdr = 1'b0;
    repeat (200) @(negedge clk_in);
    chk(blk_lock, 1'b1);
    // flag faults first, then pilot faults; block lock must survive both
    for (int f = 0; f < 2; f++) begin
      bad_flag = (f == 0);
      bad_pilot = (f == 1);
      wait_for(RLN, 1'b1);
      chk(sysref_req, 1'b1);
      chk(blk_lock, 1'b1);
      bad_flag = 1'b0;
      bad_pilot = 1'b0;
      repeat (3000) @(negedge clk_in);
      chk(emb_lock, 1'b1);
      chk(sysref_req, 1'b0);
    end
    bad_hdr = 1'b1;
    wait_for(BLK, 1'b0);
    repeat (2) @(negedge clk_in);
    chk(mb_lock, 1'b0);
    bad_hdr = 1'b0;
    wait_for(EMB, 1'b1);
    cfg_req = 1'b1;
    repeat (3) @(negedge clk_in);
    chk(enable, 1'b0);
    chk(blk_lock, 1'b0);
    emb_len = 8'h04;
    rbd = 8'h03;
    pe = 4'ha;
    cfg_req = 1'b0;
    repeat (2) @(negedge clk_in);
    chk(enable, 1'b1);
    chk(pe_out, 32'ha);
    wait_for(EMB, 1'b1);
    edge_chk(32'h100, 32'h4);
    stop_test();
  end
endmodule : slam_monitor_tb
`default_nettype wire
